// File: core/ccu_pkg.sv
// Constants, codes and reset values of the capture/compare unit.
// Assumes one 25 MHz clock; the basic time unit is half a clock period.
//
// Functional notes
// - 32 channels, resolution no finer 16 units
// - four 16-bit reloadable timers, two pairs
// - timer clock prescaled or timer-six overflow
// - first timer of pair counts external events
// - 16 channels per array, timer, mode
// - one pin per channel; 24-27 input only
// - capture copies allocated timer into channel
// - capture raises the channel's own request
// - capture on rising, falling or both
// - compare channels checked every timer update
// - match performs selected compare mode action
// - two interrupt-only modes, repeat or once
// - toggle mode inverts pin each match
// - set on match, clear on overflow, once
// - double mode: two registers toggle one pin
package ccu_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int CCU_NCH     = 32;
   localparam int CCU_ARR_CH  = 16;
   localparam int CCU_NTMR    = 4;
   localparam int CCU_TW      = 16;
   localparam int CCU_DBL_OFS = 8;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CCU_CLK_NS  = 40;
   localparam int CCU_TCL_NS  = CCU_CLK_NS / 2;
   localparam int CCU_RES_TCL = 16;
   localparam int CCU_RES_CYC = (CCU_RES_TCL * CCU_TCL_NS + CCU_CLK_NS - 1) / CCU_CLK_NS;
   localparam int CCU_PW      = 8;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [CCU_TW-1:0]  CCU_TMR_RST  = 16'h0000;
   localparam logic [CCU_TW-1:0]  CCU_TMR_MAX  = 16'hFFFF;
   localparam logic [CCU_NCH-1:0] CCU_NO_OUT   = 32'h0F00_0000;
   localparam logic [CCU_PW-1:0]  CCU_PSC_RST  = 8'h00;

   // ----------------------------------------------------------------
   // Timer clock selection
   // ----------------------------------------------------------------
   localparam logic [2:0] CCU_SEL_T6OVF = 3'h6;
   localparam logic [2:0] CCU_SEL_EXT   = 3'h7;

   // ----------------------------------------------------------------
   // Channel modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CCU_OFF      = 3'h0,
      CCU_CAP_RISE = 3'h1,
      CCU_CAP_FALL = 3'h2,
      CCU_CAP_BOTH = 3'h3,
      CCU_CMP0     = 3'h4,
      CCU_CMP1     = 3'h5,
      CCU_CMP2     = 3'h6,
      CCU_CMP3     = 3'h7
   } ccu_mode_t;

endpackage

// File: core/ccu_chan_regs.sv
// Channel register store: software port, per-channel capture port.
// Assumes callers on the same clock; read data one cycle late.
module ccu_chan_regs
   import ccu_pkg::*;
#(
   parameter int NCH = CCU_NCH,
   parameter int W   = CCU_TW
)(
   // Clock and reset
   input  wire logic                     i_clock,
   input  wire logic                     i_rst,
   // Software port
   input  wire logic                     i_wr,
   input  wire logic [$clog2(NCH)-1:0]   i_addr,
   input  wire logic [W-1:0]             i_wdata,
   output logic      [W-1:0]             o_rdata,
   // Capture port
   input  wire logic [NCH-1:0]           i_cap_en,
   input  wire logic [NCH-1:0][W-1:0]    i_cap_val,
   // All values
   output logic      [NCH-1:0][W-1:0]    o_values
);

   logic [NCH-1:0][W-1:0] mem_q;
   logic [W-1:0]          rd_q;

   // ----------------------------------------------------------------
   // Storage, capture wins over software
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         mem_q <= '0;
         rd_q  <= '0;
      end
      else
      begin
         for (int k = 0; k < NCH; k++)
         begin
            if (i_cap_en[k])
               mem_q[k] <= i_cap_val[k];
            else if (i_wr && i_addr == k[$clog2(NCH)-1:0])
               mem_q[k] <= i_wdata;
         end
         rd_q <= mem_q[i_addr];
      end
   end

   assign o_rdata  = rd_q;
   assign o_values = mem_q;

endmodule

// File: core/ccu_top.sv
// Capture/compare unit: four timers, two arrays of 16 channels.
// Assumes pins and external count inputs are asynchronous;
// the timer-six overflow pulse comes from logic on this clock.
module ccu_top
   import ccu_pkg::*;
#(
   parameter int NCH = CCU_NCH,
   parameter int TW  = CCU_TW
)(
   // Clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_rst,
   // Timer control
   input  wire logic [CCU_NTMR-1:0]       i_tmr_run,
   input  wire logic [CCU_NTMR-1:0][2:0]  i_tmr_clk_sel,
   input  wire logic [CCU_NTMR-1:0][TW-1:0] i_tmr_reload,
   input  wire logic [CCU_NTMR-1:0]       i_tmr_wr,
   input  wire logic [TW-1:0]             i_tmr_wdata,
   output logic      [CCU_NTMR-1:0][TW-1:0] o_tmr_value,
   // Timer clock sources
   input  wire logic                      i_gpt6_ovf,
   input  wire logic [1:0]                i_ext_count,
   // Timer requests
   input  wire logic [CCU_NTMR-1:0]       i_tmr_irq_en,
   input  wire logic [CCU_NTMR-1:0]       i_tmr_irq_clr,
   output logic      [CCU_NTMR-1:0]       o_tmr_flag,
   output logic      [CCU_NTMR-1:0]       o_tmr_irq,
   // Channel configuration
   input  wire logic [NCH-1:0][2:0]       i_ch_mode,
   input  wire logic [NCH-1:0]            i_ch_tmr_sel,
   input  wire logic [NCH-1:0]            i_ch_double,
   // Channel register port
   input  wire logic                      i_ch_wr,
   input  wire logic [$clog2(NCH)-1:0]    i_ch_addr,
   input  wire logic [TW-1:0]             i_ch_wdata,
   output logic      [TW-1:0]             o_ch_rdata,
   // Channel requests
   input  wire logic [NCH-1:0]            i_ch_irq_en,
   input  wire logic [NCH-1:0]            i_ch_irq_clr,
   output logic      [NCH-1:0]            o_ch_flag,
   output logic      [NCH-1:0]            o_ch_irq,
   // Channel pins
   input  wire logic [NCH-1:0]            i_pin,
   output logic      [NCH-1:0]            o_pin,
   output logic      [NCH-1:0]            o_pin_oe
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // fixed channel count and resolution
   if (NCH != CCU_NCH || TW != CCU_TW || CCU_RES_CYC < 1)
   begin : g_bad
      $error("ccu_top supports 32 channels of 16 bits only");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CCU_PW-1:0]              psc;
      logic [CCU_NTMR-1:0][TW-1:0]    tmr;
      logic [CCU_NTMR-1:0]            tflag;
      logic [CCU_NTMR-1:0]            upd;
      logic [CCU_NTMR-1:0]            ovf;
      logic [NCH+1:0]                 s1;
      logic [NCH+1:0]                 s2;
      logic [NCH+1:0]                 s3;
      logic [NCH-1:0]                 cflag;
      logic [NCH-1:0]                 lock;
      logic [NCH-1:0]                 pin;
   } ccu_state_t;

   ccu_state_t st_q;
   ccu_state_t st_d;

   logic [NCH-1:0]          cap_en;
   logic [NCH-1:0][TW-1:0]  cap_val;
   logic [NCH-1:0][TW-1:0]  values;
   logic [NCH-1:0]          match;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // channel to timer of its own pair
   function automatic logic [1:0] tmr_of(input int k, input logic sel);
      logic [1:0] r;
      r = {(k >= CCU_ARR_CH), sel};
      return r;
   endfunction

   function automatic logic psc_tap(input logic [CCU_PW-1:0] p, input logic [2:0] n);
      logic [CCU_PW-1:0] m;
      m = CCU_PW'((CCU_RES_CYC << n) - 1);
      return (p & m) == m;
   endfunction

   // ----------------------------------------------------------------
   // Channel register store
   // ----------------------------------------------------------------
   ccu_chan_regs #(
      .NCH (NCH),
      .W   (TW)
   ) u_regs (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_wr      (i_ch_wr),
      .i_addr    (i_ch_addr),
      .i_wdata   (i_ch_wdata),
      .o_rdata   (o_ch_rdata),
      .i_cap_en  (cap_en),
      .i_cap_val (cap_val),
      .o_values  (values)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic       tick;
      logic [1:0] t;
      logic [NCH-1:0] rise;
      logic [NCH-1:0] fall;
      logic [NCH-1:0] ev;
      st_d    = st_q;
      rise    = '0;
      fall    = '0;
      cap_en  = '0;
      cap_val = '0;
      match   = '0;
      ev      = '0;
      tick    = 1'b0;
      t       = 2'h0;

      // Input synchronisers
      st_d.s1 = {i_ext_count, i_pin};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      rise    = st_q.s2[NCH-1:0] & ~st_q.s3[NCH-1:0];
      fall    = ~st_q.s2[NCH-1:0] & st_q.s3[NCH-1:0];

      st_d.psc = st_q.psc + CCU_PW'(1);

      // Timers
      for (int i = 0; i < CCU_NTMR; i++)
      begin
         unique case (i_tmr_clk_sel[i])
            CCU_SEL_T6OVF: tick = i_gpt6_ovf;
            // external count on first timers only
            CCU_SEL_EXT:   tick = (i % 2 == 0) &&
                                  st_q.s2[NCH + i/2] && !st_q.s3[NCH + i/2];
            default:       tick = psc_tap(st_q.psc, i_tmr_clk_sel[i]);
         endcase
         tick        = tick & i_tmr_run[i];
         st_d.upd[i] = 1'b0;
         st_d.ovf[i] = 1'b0;
         if (i_tmr_wr[i])
            st_d.tmr[i] = i_tmr_wdata;
         else if (tick)
         begin
            st_d.upd[i] = 1'b1;
            if (st_q.tmr[i] == CCU_TMR_MAX)
            begin
               st_d.tmr[i] = i_tmr_reload[i];
               st_d.ovf[i] = 1'b1;
            end
            else
               st_d.tmr[i] = st_q.tmr[i] + TW'(1);
         end
         st_d.tflag[i] = (st_q.tflag[i] & ~i_tmr_irq_clr[i]) | st_d.ovf[i];
      end

      // Channels
      for (int k = 0; k < NCH; k++)
      begin
         t = tmr_of(k, i_ch_tmr_sel[k]);
         // Period boundary frees once-per-period modes
         if (st_q.ovf[t])
         begin
            st_d.lock[k] = 1'b0;
            if (i_ch_mode[k] == CCU_CMP3)
               st_d.pin[k] = 1'b0;
         end
         match[k] = i_ch_mode[k][2] && st_q.upd[t] && st_q.tmr[t] == values[k];
         unique case (i_ch_mode[k])
            CCU_OFF: ;
            CCU_CAP_RISE, CCU_CAP_FALL, CCU_CAP_BOTH:
            begin
               cap_en[k] = (i_ch_mode[k][0] && rise[k]) || (i_ch_mode[k][1] && fall[k]);
               cap_val[k] = st_q.tmr[t];
               ev[k] = cap_en[k];
            end
            CCU_CMP0: ev[k] = match[k];
            CCU_CMP1:
            begin
               ev[k] = match[k];
               if (match[k])
                  st_d.pin[k] = ~st_q.pin[k];
            end
            CCU_CMP2:
            begin
               ev[k] = match[k] && !st_d.lock[k];
               if (ev[k])
                  st_d.lock[k] = 1'b1;
            end
            CCU_CMP3:
            begin
               ev[k] = match[k] && !st_d.lock[k];
               if (ev[k])
               begin
                  st_d.lock[k] = 1'b1;
                  st_d.pin[k]  = 1'b1;
               end
            end
         endcase
      end

      // partner match also toggles shared pin
      for (int k = 0; k < NCH; k++)
      begin
         if ((k % CCU_ARR_CH) < CCU_DBL_OFS && i_ch_double[k] &&
             i_ch_mode[k] == CCU_CMP1 && match[(k + CCU_DBL_OFS) % NCH] && !match[k])
            st_d.pin[k] = ~st_q.pin[k];
      end

      st_d.cflag = (st_q.cflag & ~i_ch_irq_clr) | ev;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_q     <= '0;
         st_q.psc <= CCU_PSC_RST;
         st_q.tmr <= {CCU_NTMR{CCU_TMR_RST}};
      end
      else
         st_q <= st_d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // requests forwarded only while enabled
   assign o_tmr_irq   = st_q.tflag & i_tmr_irq_en;
   assign o_tmr_flag  = st_q.tflag;
   assign o_tmr_value = st_q.tmr;
   assign o_ch_flag   = st_q.cflag;
   assign o_ch_irq    = st_q.cflag & i_ch_irq_en;
   assign o_pin       = st_q.pin;

   // pin driven in pin modes, not 24-27
   always_comb
   begin
      for (int k = 0; k < NCH; k++)
         o_pin_oe[k] = (i_ch_mode[k] == CCU_CMP1 || i_ch_mode[k] == CCU_CMP3) &&
                       !CCU_NO_OUT[k];
   end

endmodule

// File: tb/ccu_top_asserts.sv
// Checker for the capture/compare unit top level ports.
// Assumes one clock domain and the asynchronous high reset.
module ccu_top_asserts
   import ccu_pkg::*;
#(
   parameter int NCH = CCU_NCH,
   parameter int TW  = CCU_TW
)(
   input wire logic                        i_clock,
   input wire logic                        i_rst,
   input wire logic [CCU_NTMR-1:0][TW-1:0] i_tmr_reload,
   input wire logic [CCU_NTMR-1:0]         i_tmr_wr,
   input wire logic [CCU_NTMR-1:0][TW-1:0] o_tmr_value,
   input wire logic [CCU_NTMR-1:0]         i_tmr_irq_en,
   input wire logic [CCU_NTMR-1:0]         i_tmr_irq_clr,
   input wire logic [CCU_NTMR-1:0]         o_tmr_flag,
   input wire logic [CCU_NTMR-1:0]         o_tmr_irq,
   input wire logic [NCH-1:0][2:0]         i_ch_mode,
   input wire logic                        i_ch_wr,
   input wire logic [$clog2(NCH)-1:0]      i_ch_addr,
   input wire logic [TW-1:0]               i_ch_wdata,
   input wire logic [TW-1:0]               o_ch_rdata,
   input wire logic [NCH-1:0]              i_ch_irq_en,
   input wire logic [NCH-1:0]              i_ch_irq_clr,
   input wire logic [NCH-1:0]              o_ch_flag,
   input wire logic [NCH-1:0]              o_ch_irq,
   input wire logic [NCH-1:0]              o_pin,
   input wire logic [NCH-1:0]              o_pin_oe
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   a_no_out_pins: assert property ((o_pin_oe & CCU_NO_OUT) == '0)
      else $error("output enable on an input-only channel");
   a_tmr_irq_gate: assert property (o_tmr_irq == (o_tmr_flag & i_tmr_irq_en))
      else $error("timer request not flag and enable");
   a_ch_irq_gate: assert property (o_ch_irq == (o_ch_flag & i_ch_irq_en))
      else $error("channel request not flag and enable");
   a_ch_flag_hold: assert property (($past(o_ch_flag) & ~o_ch_flag & ~$past(i_ch_irq_clr)) == '0)
      else $error("channel flag dropped without clear");
   a_tmr_flag_hold: assert property (($past(o_tmr_flag) & ~o_tmr_flag & ~$past(i_tmr_irq_clr)) == '0)
      else $error("timer flag dropped without clear");
   a_rd_latency: assert property ((i_ch_wr && i_ch_mode[i_ch_addr] == 3'h0) ##1
      (!i_ch_wr && $stable(i_ch_addr)) |=> o_ch_rdata == $past(i_ch_wdata, 2))
      else $error("channel read data not the written value");
   for (genvar t = 0; t < CCU_NTMR; t++)
   begin : g_tmr
      a_tmr_ovf_load: assert property ($rose(o_tmr_flag[t]) |->
         $past(o_tmr_value[t]) == CCU_TMR_MAX && o_tmr_value[t] == $past(i_tmr_reload[t]))
         else $error("timer flag without overflow reload");
      a_tmr_step: assert property ($changed(o_tmr_value[t]) |-> $past(i_tmr_wr[t]) ||
         o_tmr_value[t] == $past(o_tmr_value[t]) + 16'h0001 ||
         $past(o_tmr_value[t]) == CCU_TMR_MAX)
         else $error("timer moved by other than one step");
   end
   for (genvar k = 0; k < NCH; k++)
   begin : g_ch
      a_pin_src_mode: assert property ($changed(o_pin[k]) |->
         $past(i_ch_mode[k]) inside {3'h5, 3'h7})
         else $error("pin moved outside a pin compare mode");
   end
endmodule

bind ccu_top ccu_top_asserts #(.NCH(NCH), .TW(TW)) u_ccu_top_asserts (
   .i_clock(i_clock), .i_rst(i_rst), .i_tmr_reload(i_tmr_reload), .i_tmr_wr(i_tmr_wr),
   .o_tmr_value(o_tmr_value), .i_tmr_irq_en(i_tmr_irq_en), .i_tmr_irq_clr(i_tmr_irq_clr),
   .o_tmr_flag(o_tmr_flag), .o_tmr_irq(o_tmr_irq), .i_ch_mode(i_ch_mode),
   .i_ch_wr(i_ch_wr), .i_ch_addr(i_ch_addr), .i_ch_wdata(i_ch_wdata),
   .o_ch_rdata(o_ch_rdata), .i_ch_irq_en(i_ch_irq_en), .i_ch_irq_clr(i_ch_irq_clr),
   .o_ch_flag(o_ch_flag), .o_ch_irq(o_ch_irq), .o_pin(o_pin), .o_pin_oe(o_pin_oe));

// File: tb/ccu_pin_src.sv
// Signal sources on the channel pins and count inputs.
// Assumes the bench sets the wanted levels; slow adds one clock.
module ccu_pin_src
(
   input  wire logic        i_clock,
   input  wire logic        i_slow,
   input  wire logic [31:0] i_lvl,
   input  wire logic [1:0]  i_ext,
   output logic      [31:0] o_pin,
   output logic      [1:0]  o_ext_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] lag_q;

   always @(posedge i_clock) lag_q <= i_lvl;
   assign o_pin       = i_slow ? lag_q : i_lvl;
   assign o_ext_count = i_ext;
endmodule

// File: tb/ccu_top_tb.sv
// Self-checking bench for the capture/compare unit.
// Assumes the pin source model and the bound checker.
module ccu_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ccu_pkg::*;
   logic             clk, rst, gpt, cwr, slow;
   logic [1:0]       ext, extc;
   logic [3:0]       run, twr, tien, ticlr, tflag, tirq;
   logic [3:0][2:0]  sel;
   logic [3:0][15:0] reload, tval;
   logic [15:0]      twd, cwd, rd;
   logic [4:0]       caddr;
   logic [31:0][2:0] mode;
   logic [31:0]      tsel, dbl, cien, ciclr, cflag, cirq, lvl, pins, pin, oe;
   int               err_count, n_tests, cycles;

   ccu_top u_ccu_top (.i_clock(clk), .i_rst(rst), .i_tmr_run(run), .i_tmr_clk_sel(sel),
      .i_tmr_reload(reload), .i_tmr_wr(twr), .i_tmr_wdata(twd), .o_tmr_value(tval),
      .i_gpt6_ovf(gpt), .i_ext_count(extc), .i_tmr_irq_en(tien), .i_tmr_irq_clr(ticlr),
      .o_tmr_flag(tflag), .o_tmr_irq(tirq), .i_ch_mode(mode), .i_ch_tmr_sel(tsel),
      .i_ch_double(dbl), .i_ch_wr(cwr), .i_ch_addr(caddr), .i_ch_wdata(cwd),
      .o_ch_rdata(rd), .i_ch_irq_en(cien), .i_ch_irq_clr(ciclr), .o_ch_flag(cflag),
      .o_ch_irq(cirq), .i_pin(pins), .o_pin(pin), .o_pin_oe(oe));
   ccu_pin_src u_ccu_pin_src (.i_clock(clk), .i_slow(slow), .i_lvl(lvl), .i_ext(ext),
      .o_pin(pins), .o_ext_count(extc));

   always #20 clk = ~clk;

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wtm(input int i, input logic [15:0] v);
      @(posedge clk);
      twr[i] <= 1'b1;
      twd    <= v;
      @(posedge clk);
      twr[i] <= 1'b0;
   endtask

   task automatic wch(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      cwr   <= 1'b1;
      caddr <= a;
      cwd   <= d;
      @(posedge clk);
      cwr   <= 1'b0;
   endtask

   task automatic tick;
      @(posedge clk);
      gpt <= 1'b1;
      @(posedge clk);
      gpt <= 1'b0;
      cyc(3);
   endtask

   task automatic t_timer;
      int n;
      reload[1] <= 16'h1234;
      wtm(1, 16'hFFFD);
      run[1] <= 1'b1;
      for (n = 0; n < 40 && tflag[1] !== 1'b1; n++)
         cyc(1);
      chk(tval[1], 16'h1234);
      chk(tirq[1], 1'b0);
      for (n = 0; n < 20 && tval[1] === 16'h1234; n++)
         cyc(1);
      chk(n, 8);
      @(posedge clk);
      tien[1] <= 1'b1;
      cyc(1);
      chk(tirq[1], 1'b1);
      @(posedge clk);
      ticlr[1] <= 1'b1;
      @(posedge clk);
      ticlr[1] <= 1'b0;
      run[1]   <= 1'b0;
      cyc(1);
      chk(tflag[1], 1'b0);
      $display("timer test done");
   endtask

   task automatic t_capture;
      logic [15:0] tv;
      logic        exp;
      tsel[3] <= 1'b1;
      cien[3] <= 1'b1;
      wtm(0, 16'h5555);
      for (int m = 1; m < 4; m++)
         for (int e = 0; e < 2; e++)
         begin
            tv  = 16'h0A00 + 16'(m * 2 + e);
            exp = (e == 0) ? (m != 2) : (m != 1);
            wtm(1, tv);
            wch(5'd3, 16'h0000);
            @(posedge clk);
            mode[3] <= 3'(m);
            slow    <= (m == 3);
            lvl[3]  <= ~lvl[3];
            cyc(6);
            chk(cflag[3], exp);
            chk(cirq[3], exp);
            @(posedge clk);
            caddr <= 5'd3;
            cyc(2);
            chk(rd, exp ? tv : 16'h0000);
            @(posedge clk);
            ciclr[3] <= 1'b1;
            @(posedge clk);
            ciclr[3] <= 1'b0;
         end
      mode[3] <= 3'h0;
      $display("capture test done");
   endtask

   task automatic t_compare;
      for (int k = 16; k < 26; k++)
         wch(5'(k), 16'h0100);
      mode[16] <= 3'h5;
      mode[17] <= 3'h7;
      mode[18] <= 3'h6;
      mode[19] <= 3'h4;
      mode[25] <= 3'h5;
      sel[2]    <= CCU_SEL_T6OVF;
      run[2]    <= 1'b1;
      reload[2] <= 16'h00FF;
      wtm(2, 16'h00FF);
      tick;
      chk(pin[19:16], 4'h3);
      chk(cflag[20:16], 5'h0F);
      chk(oe[25:16], 10'h003);
      @(posedge clk);
      ciclr <= 32'h000F_0000;
      @(posedge clk);
      ciclr <= 32'h0;
      wtm(2, 16'h00FF);
      tick;
      chk(pin[19:16], 4'h2);
      chk(cflag[19:16], 4'h9);
      wtm(2, 16'hFFFF);
      tick;
      chk(pin[17], 1'b0);
      chk(tflag[2], 1'b1);
      tick;
      chk(pin[17:16], 2'h3);
      chk(cflag[18], 1'b1);
      wch(5'd24, 16'h0101);
      mode[24] <= 3'h4;
      dbl[16]  <= 1'b1;
      tick;
      chk(pin[16], 1'b0);
      chk(cflag[24], 1'b1);
      run[2] <= 1'b0;
      $display("compare test done");
   endtask

   task automatic t_ext;
      @(posedge clk);
      sel[0] <= CCU_SEL_EXT;
      sel[1] <= CCU_SEL_EXT;
      sel[2] <= CCU_SEL_EXT;
      run    <= 4'h7;
      ext    <= 2'h3;
      cyc(6);
      chk(tval[0], 16'h5556);
      chk(tval[1], 16'h0A07);
      chk(tval[2], 16'h0102);
      run <= 4'h0;
      ext <= 2'h0;
      $display("count input test done");
   endtask

   initial
   begin
      clk = 0; rst = 1; gpt = 0; cwr = 0; slow = 0; ext = '0; run = '0; twr = '0;
      tien = '0; ticlr = '0; sel = '0; reload = '0; twd = '0; cwd = '0; caddr = '0;
      mode = '0; tsel = '0; dbl = '0; cien = '0; ciclr = '0; lvl = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk(tval, 64'h0);
      chk(cflag, 32'h0);
      t_timer;
      t_capture;
      t_compare;
      t_ext;
      report_and_stop;
   end
endmodule
